// ==== inc/smc_params.svh ====
// Offsets, field positions, reset values and timing counts of the supply monitor configuration.
// Assumes a 32-bit classic Wishbone slave with word addressing on adr_i[11:2].
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
// Register indices; byte address is four times the index
`define SMC_IDX_PAGE 10'h000
`define SMC_IDX_CFG 10'h0D2
`define SMC_IDX_UV_STAT 10'h0F0
`define SMC_IDX_OV_STAT 10'h0F1
// Page values
`define SMC_PAGE_FIRST 8'h04
`define SMC_PAGE_LAST 8'h10
`define SMC_PAGE_HV_LAST 8'h03
// Field positions of the sense channel layout
`define SMC_RANGE_HI 15
`define SMC_RANGE_LO 13
`define SMC_DIFF_BIT 12
`define SMC_UVF_HI 11
`define SMC_UVF_LO 8
`define SMC_UV_EN_BIT 6
`define SMC_OVF_HI 5
`define SMC_OVF_LO 2
`define SMC_OV_EN_BIT 0
`define SMC_HV_OV_EN_BIT 0
// Reset values
`define SMC_CFG_RST 16'h0000
`define SMC_PAGE_RST 8'h00
// Timing: filter tick period and clock period in ns
`define SMC_CLK_NS 10
`define SMC_TICK_NS 100
`define SMC_TICK_CYC (`SMC_TICK_NS / `SMC_CLK_NS)
`endif

// ==== inc/smc_pkg.sv ====
// Types shared by the supply monitor channel configuration block.
// Assumes smc_params.svh for the field layout it mirrors.
package smc_pkg;
  // Sense channel configuration word
  typedef struct packed {
    logic [2:0] input_range_select;
    logic differential_mode_enable;
    logic [3:0] undervoltage_filter_width;
    logic rsv7;
    logic undervoltage_comparator_enable;
    logic [3:0] overvoltage_filter_width;
    logic rsv1;
    logic overvoltage_comparator_enable;
  } smc_cfg_t;

  // Range codes
  typedef enum logic [2:0] {
    SMC_RNG_OFF0 = 3'h0,
    SMC_RNG_OFF1 = 3'h1,
    SMC_RNG_OFF2 = 3'h2,
    SMC_RNG_HIGH = 3'h3,
    SMC_RNG_MID = 3'h4,
    SMC_RNG_LOW = 3'h5,
    SMC_RNG_DIRECT = 3'h6,
    SMC_RNG_RSVD = 3'h7
  } smc_range_t;

  localparam int SMC_NCH = 13;
  localparam int SMC_NHV = 4;
  localparam int SMC_CW = 10;
endpackage : smc_pkg

// ==== hw/smc_top.sv ====
// Paged configuration of the supply monitor channels; sense channel comparators are glitch-filtered, high-voltage ones are not.
// Assumes a classic Wishbone master and comparator inputs synchronous to clk_i.
// How it works
// - one config copy per sense channel, chosen by page values 4 to 16.
// - range codes 0-2 disconnect, 3-5 scaled, 6 direct, 7 reserved.
// - bit 12 enables differential mode, ignored on even-numbered channels.
// - undervoltage pulses narrower than the bits 11-8 width are suppressed.
// - sampling adds at most 400 ns on top of the filter width.
// - bit 6 enables the undervoltage comparator.
// - overvoltage filter from bits 5-2, same table as undervoltage.
// - bit 0 enables the overvoltage comparator.
// - on high-voltage pages bit 0 enables that overvoltage comparator.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`include "smc_params.svh"

module smc_top
  import smc_pkg::*;
#(
  parameter int TICK_CYC = `SMC_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [SMC_NCH-1:0] uv_raw_i,
  input wire logic [SMC_NCH-1:0] ov_raw_i,
  input wire logic [SMC_NHV-1:0] hv_ov_raw_i,
  output logic [SMC_NCH-1:0] uv_fault_o,
  output logic [SMC_NCH-1:0] ov_fault_o,
  output logic [SMC_NHV-1:0] hv_ov_fault_o,
  output logic [SMC_NCH-1:0] input_connected_o,
  output logic [SMC_NCH-1:0] scaled_range_o,
  output logic [SMC_NCH-1:0] diff_mode_o
);

  // Filter width in ticks of the filter time base
  function automatic logic [SMC_CW-1:0] smc_width(input logic [3:0] code);
    int ns;
    ns = 2000;
    case (code)
      4'h3: ns = 4000;
      4'h4: ns = 5000;
      4'h5: ns = 6000;
      4'h6: ns = 7500;
      4'h7: ns = 8000;
      4'h8: ns = 10000;
      4'h9: ns = 20000;
      4'hA: ns = 40000;
      4'hB: ns = 50000;
      4'hC: ns = 60000;
      4'hD: ns = 75000;
      4'hE: ns = 80000;
      4'hF: ns = 100000;
      // Reserved codes fall back to the shortest width
      default: ns = 2000;
    endcase
    return SMC_CW'(ns / `SMC_TICK_NS);
  endfunction : smc_width

  // Bus request decode
  logic bus_req;
  logic bus_wr;
  logic [9:0] widx;
  logic page_sel_ok;
  logic page_hv;
  logic [3:0] ch_idx;
  logic [15:0] wr_mask;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign widx = wb_adr_i[11:2];
  assign wr_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Registers
  logic [7:0] page_ff;
  smc_cfg_t cfg_ff [SMC_NCH];
  logic [SMC_NHV-1:0] hv_ov_en_ff;

  assign page_sel_ok = (page_ff >= `SMC_PAGE_FIRST) && (page_ff <= `SMC_PAGE_LAST);
  assign page_hv = (page_ff <= `SMC_PAGE_HV_LAST);
  assign ch_idx = page_sel_ok ? 4'(page_ff - `SMC_PAGE_FIRST) : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_ff <= `SMC_PAGE_RST;
    end else if (bus_wr && widx == `SMC_IDX_PAGE && wb_sel_i[0]) begin
      page_ff <= wb_dat_i[7:0];
    end
  end

  // Paged config copies
  genvar gi;
  generate
    for (gi = 0; gi < SMC_NCH; gi++) begin : g_cfg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cfg_ff[gi] <= `SMC_CFG_RST;
        end else if (bus_wr && widx == `SMC_IDX_CFG && page_sel_ok && ch_idx == 4'(gi)) begin
          // Reserved bits are stored as written
          cfg_ff[gi] <= (cfg_ff[gi] & ~wr_mask) | (wb_dat_i[15:0] & wr_mask);
        end
      end
    end
  endgenerate

  generate
    for (gi = 0; gi < SMC_NHV; gi++) begin : g_hv
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hv_ov_en_ff[gi] <= 1'b0;
        end else if (bus_wr && widx == `SMC_IDX_CFG && page_hv && page_ff[1:0] == 2'(gi)
                     && wb_sel_i[0]) begin
          hv_ov_en_ff[gi] <= wb_dat_i[`SMC_HV_OV_EN_BIT];
        end
      end
    end
  endgenerate

  // Read mux
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (widx == `SMC_IDX_PAGE) begin
      nxt_rdata = {24'h00_0000, page_ff};
    end else if (widx == `SMC_IDX_CFG && page_sel_ok) begin
      nxt_rdata = {16'h0000, cfg_ff[ch_idx]};
    end else if (widx == `SMC_IDX_CFG && page_hv) begin
      nxt_rdata = {31'h0000_0000, hv_ov_en_ff[page_ff[1:0]]};
    end else if (widx == `SMC_IDX_UV_STAT) begin
      nxt_rdata = {12'h000, hv_ov_fault_o, 3'h0, uv_fault_o};
    end else if (widx == `SMC_IDX_OV_STAT) begin
      nxt_rdata = {19'h0_0000, ov_fault_o};
    end else begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= nxt_rdata;
    end
  end

  // Filter time base, one-cycle enable every TICK_CYC clocks
  localparam int TW = $clog2(TICK_CYC + 1);
  logic [TW-1:0] tick_cnt_ff;
  logic tick_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TW'(TICK_CYC - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // Per channel filters and mode decode
  generate
    for (gi = 0; gi < SMC_NCH; gi++) begin : g_ch
      logic [SMC_CW-1:0] uv_cnt_ff;
      logic [SMC_CW-1:0] ov_cnt_ff;
      logic [SMC_CW-1:0] uv_w;
      logic [SMC_CW-1:0] ov_w;
      logic uv_live;
      logic ov_live;

      assign uv_w = smc_width(cfg_ff[gi].undervoltage_filter_width);
      assign ov_w = smc_width(cfg_ff[gi].overvoltage_filter_width);
      assign uv_live = uv_raw_i[gi] & cfg_ff[gi].undervoltage_comparator_enable;
      assign ov_live = ov_raw_i[gi] & cfg_ff[gi].overvoltage_comparator_enable;

      // Count whole ticks the condition stands; a short pulse resets the count
      // One tick past the width, as the first tick may follow the raw edge at once
      always_ff @(posedge clk_i) begin
        if (rst_i || !uv_live) begin
          uv_cnt_ff <= '0;
        end else if (tick_ff && uv_cnt_ff <= uv_w) begin
          uv_cnt_ff <= uv_cnt_ff + 1'b1;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i || !ov_live) begin
          ov_cnt_ff <= '0;
        end else if (tick_ff && ov_cnt_ff <= ov_w) begin
          ov_cnt_ff <= ov_cnt_ff + 1'b1;
        end
      end

      // Tick alignment adds under one tick period, inside the 400 ns allowance
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          uv_fault_o[gi] <= 1'b0;
          ov_fault_o[gi] <= 1'b0;
        end else begin
          uv_fault_o[gi] <= uv_live && (uv_cnt_ff > uv_w);
          ov_fault_o[gi] <= ov_live && (ov_cnt_ff > ov_w);
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          input_connected_o[gi] <= 1'b0;
          scaled_range_o[gi] <= 1'b0;
          diff_mode_o[gi] <= 1'b0;
        end else begin
          input_connected_o[gi] <= (cfg_ff[gi].input_range_select == SMC_RNG_HIGH) ||
                                   (cfg_ff[gi].input_range_select == SMC_RNG_MID) ||
                                   (cfg_ff[gi].input_range_select == SMC_RNG_LOW) ||
                                   (cfg_ff[gi].input_range_select == SMC_RNG_DIRECT);
          scaled_range_o[gi] <= (cfg_ff[gi].input_range_select == SMC_RNG_HIGH) ||
                                (cfg_ff[gi].input_range_select == SMC_RNG_MID) ||
                                (cfg_ff[gi].input_range_select == SMC_RNG_LOW);
          // Channel number is gi+1, so even-indexed entries are odd channels
          diff_mode_o[gi] <= cfg_ff[gi].differential_mode_enable && ((gi % 2) == 0);
        end
      end
    end
  endgenerate

  // High-voltage overvoltage: enable gating only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_ov_fault_o <= '0;
    end else begin
      hv_ov_fault_o <= hv_ov_raw_i & hv_ov_en_ff;
    end
  end

endmodule : smc_top

// ==== tb/smc_properties.sv ====
// Port checker of the supply monitor configuration block.
// Assumes binding into smc_top run with TICK_CYC of 1.
`timescale 1ns/10ps
module smc_properties
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [SMC_NCH-1:0] uv_raw_i,
  input wire logic [SMC_NCH-1:0] ov_raw_i,
  input wire logic [SMC_NHV-1:0] hv_ov_raw_i,
  input wire logic [SMC_NCH-1:0] uv_fault_o,
  input wire logic [SMC_NCH-1:0] ov_fault_o,
  input wire logic [SMC_NHV-1:0] hv_ov_fault_o,
  input wire logic [SMC_NCH-1:0] input_connected_o,
  input wire logic [SMC_NCH-1:0] scaled_range_o,
  input wire logic [SMC_NCH-1:0] diff_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_uv_quiet; !uv_raw_i[0] [*3]; endsequence
  sequence s_ov_quiet; !ov_raw_i[0] [*3]; endsequence
  chk_ack_latency:
    assert property (s_req |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_hv_cause:
    assert property ((hv_ov_fault_o & ~$past(hv_ov_raw_i)) == 4'h0) else $error("hv fault");
  chk_diff_even:
    assert property ((diff_mode_o & 13'h0AAA) == 13'h0000) else $error("diff on even");
  chk_scaled_conn:
    assert property ((scaled_range_o & ~input_connected_o) == 13'h0000) else $error("range");
  chk_uv_width:
    assert property ($rose(uv_fault_o[0]) |-> $past(uv_raw_i[0], 20)) else $error("uv early");
  chk_ov_width:
    assert property ($rose(ov_fault_o[0]) |-> $past(ov_raw_i[0], 20)) else $error("ov early");
  chk_uv_quiet:
    assert property (s_uv_quiet |-> !uv_fault_o[0]) else $error("uv stuck");
  chk_ov_quiet:
    assert property (s_ov_quiet |-> !ov_fault_o[0]) else $error("ov stuck");
endmodule : smc_properties

bind smc_top smc_properties chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .uv_raw_i, .ov_raw_i, .hv_ov_raw_i, .uv_fault_o, .ov_fault_o, .hv_ov_fault_o,
  .input_connected_o, .scaled_range_o, .diff_mode_o);

// ==== tb/tb_top.sv ====
// Self-checking bench of the paged supply monitor configuration.
// Assumes smc_top with TICK_CYC of 1 and the bound port checker.
`timescale 1ns/10ps
`include "smc_params.svh"
module tb_top import smc_pkg::*;;
  localparam logic [11:0] A_PG = {`SMC_IDX_PAGE, 2'b00};
  localparam logic [11:0] A_CF = {`SMC_IDX_CFG, 2'b00};
  localparam logic [11:0] A_UV = {`SMC_IDX_UV_STAT, 2'b00};
  localparam logic [11:0] A_OV = {`SMC_IDX_OV_STAT, 2'b00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0;
  logic [SMC_NCH-1:0] uv_raw_i = '0;
  logic [SMC_NCH-1:0] ov_raw_i = '0;
  logic [SMC_NHV-1:0] hv_ov_raw_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [SMC_NCH-1:0] uv_fault_o, ov_fault_o, input_connected_o, scaled_range_o, diff_mode_o;
  logic [SMC_NHV-1:0] hv_ov_fault_o;
  logic [SMC_NCH-1:0] e_con, e_scl, e_dif;
  logic [15:0] cm [SMC_NCH];
  logic [31:0] exp_q [$];
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 79073;
  int r;

  smc_top #(.TICK_CYC(1)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .uv_raw_i, .ov_raw_i, .hv_ov_raw_i,
    .uv_fault_o, .ov_fault_o, .hv_ov_fault_o, .input_connected_o, .scaled_range_o,
    .diff_mode_o);

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_mismatch++;
      tally_and_finish();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // Raise one raw input and count edges until its fault shows
  task automatic rise(input bit ov, input int w);
    int n;
    if (ov) ov_raw_i[0] <= 1'b1;
    else uv_raw_i[0] <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((ov ? ov_fault_o[0] : uv_fault_o[0]) !== 1'b1 && n < 1100);
    if (n >= 1100) begin
      n_mismatch++;
      tally_and_finish();
    end
    check(32'(n >= w && n <= w + 4), 32'h1);
  endtask : rise

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      check(wb_dat_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, A_PG, 32'h4);
    rd(A_CF, 32'h0);
    for (int p = 4; p <= 16; p++) begin
      r = $random(seed);
      cm[p-4] = {3'((p - 4) % 7), r[12:0] & 13'h1F7D | 13'h0208};
      wb(1'b1, A_PG, 32'(p));
      wb(1'b1, A_CF, {16'h0, cm[p-4]});
    end
    wb(1'b1, A_PG, 32'h11);
    wb(1'b1, A_CF, 32'hFFFF);
    rd(A_CF, 32'h0);
    rd(12'hFFC, 32'h0);
    for (int p = 4; p <= 16; p++) begin
      wb(1'b1, A_PG, 32'(p));
      rd(A_CF, {16'h0, cm[p-4]});
    end
    // Upper byte lane only, on the last page
    wb_sel_i <= 4'h2;
    wb(1'b1, A_CF, 32'h0);
    wb_sel_i <= 4'h3;
    cm[12][15:8] = 8'h00;
    rd(A_CF, {16'h0, cm[12]});
    for (int i = 0; i < SMC_NCH; i++) begin
      e_con[i] = cm[i][15:13] inside {[3'h3:3'h6]};
      e_scl[i] = cm[i][15:13] inside {[3'h3:3'h5]};
      e_dif[i] = cm[i][12] & ~i[0];
    end
    check(input_connected_o, e_con);
    check(scaled_range_o, e_scl);
    check(diff_mode_o, e_dif);
    $display("test pages done");
    wb(1'b1, A_PG, 32'h4);
    wb(1'b1, A_CF, 32'h024D);
    uv_raw_i[0] <= 1'b1;
    repeat (15) begin
      @(posedge clk_i);
      check(uv_fault_o[0], 32'h0);
    end
    uv_raw_i[0] <= 1'b0;
    repeat (3) @(posedge clk_i);
    rise(1'b0, 20);
    rd(A_UV, 32'h1);
    rise(1'b1, 40);
    rd(A_OV, 32'h1);
    wb(1'b1, A_CF, 32'h020C);
    repeat (30) @(posedge clk_i);
    check({ov_fault_o[0], uv_fault_o[0]}, 32'h0);
    uv_raw_i[0] <= 1'b0;
    ov_raw_i[0] <= 1'b0;
    $display("test filters done");
    wb(1'b1, A_PG, 32'h0);
    wb(1'b1, A_CF, 32'h1);
    hv_ov_raw_i <= 4'hF;
    repeat (3) @(posedge clk_i);
    check(hv_ov_fault_o, 32'h1);
    rd(A_CF, 32'h1);
    $display("test high channel done");
    tally_and_finish();
  end
endmodule : tb_top
